/* src/gssr_pkg.sv */
/*
 Shared constants and carrier types for the gated serial shift register.
 Assumes a single 100 MHz clock domain; no software-visible registers.
*/
package gssr_pkg;

	localparam int unsigned GSSR_STAGES     = 8;
	localparam int unsigned GSSR_FIFO_DEPTH = 4;
	localparam int unsigned GSSR_CLK_MHZ    = 100;

	localparam logic [GSSR_STAGES-1:0] GSSR_STAGE_RST = 8'h00;
	localparam logic                   GSSR_SCLK_RST  = 1'b1;

	typedef struct packed {
		logic shift_clock;
		logic gate_a;
		logic gate_b;
	} gssr_serial_t;

	typedef logic [GSSR_STAGES-1:0] gssr_word_t;

endpackage

/* src/gssr_shift_register.sv */
/*
 Eight-stage gated serial-in, parallel-out shift register with a
 four-word snapshot FIFO on the parallel word path.
 Assumes all inputs synchronous to clk; shift_clock is a sampled level.
*/
`timescale 1ns/100ps

// Overview of operation
// - Eight stages, each driven on its own output
// - Stages update only on shift_clock rising edge
// - Clear low forces all stages low at once
// - Either gate input low loads zero
// - First stage loads AND of both gates
// - Each later stage takes its predecessor
// - Without edge or clear, stages hold
// - Serial value sampled only at the edge

module gssr_fifo
	import gssr_pkg::*;
#(
	parameter int unsigned WIDTH = GSSR_STAGES,
	parameter int unsigned DEPTH = GSSR_FIFO_DEPTH
)
(
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             clk_en,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR   = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wr_ptr_q;
	logic [PW-1:0]    wr_ptr_d;
	logic [PW-1:0]    rd_ptr_q;
	logic [PW-1:0]    rd_ptr_d;
	logic [CW-1:0]    count_q;
	logic [CW-1:0]    count_d;
	logic             push;
	logic             pop;

	assign in_ready  = (count_q != FULL_COUNT);
	assign out_valid = (count_q != '0);
	assign out_data  = mem_q[rd_ptr_q];

	always_comb
	begin
		push     = in_valid && in_ready && clk_en;
		pop      = out_valid && out_ready && clk_en;
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		count_d  = count_q;
		if (push)
		begin
			wr_ptr_d = (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
		end
		if (pop)
		begin
			rd_ptr_d = (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
		end
		if (push && !pop)
		begin
			count_d = count_q + 1'b1;
		end
		else if (pop && !push)
		begin
			count_d = count_q - 1'b1;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end
		else
		begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q  <= count_d;
		end
	end

	// Storage needs no reset; out_valid masks stale entries
	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

endmodule

module gssr_shift_register
	import gssr_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         clk_en,
	input  wire gssr_serial_t serial_in,
	input  wire logic         async_clear_n,
	output gssr_word_t        stage_out,
	output logic              word_valid,
	input  wire logic         word_ready,
	output gssr_word_t        word_data,
	output logic              snap_ready
);

	gssr_word_t stage_q;
	gssr_word_t stage_d;
	logic       sclk_prev_q;
	logic       sclk_prev_d;
	logic       shift_edge;
	logic       first_bit;
	logic       stage_clr;

	// Clear acts without the clock, so it joins the async reset
	assign stage_clr = reset || !async_clear_n;

	always_comb
	begin
		sclk_prev_d = sclk_prev_q;
		if (clk_en)
		begin
			sclk_prev_d = serial_in.shift_clock;
		end
		// Only low-to-high counts; falling edges are ignored
		shift_edge = clk_en && serial_in.shift_clock
			&& !sclk_prev_q;
		// Gates sampled in the edge cycle only
		first_bit = serial_in.gate_a
			&& serial_in.gate_b;
		stage_d = stage_q;
		if (shift_edge)
		begin
			stage_d = {stage_q[GSSR_STAGES-2:0], first_bit};
		end
	end

	// Reset to high so a clock already high is not seen as an edge
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sclk_prev_q <= GSSR_SCLK_RST;
		end
		else
		begin
			sclk_prev_q <= sclk_prev_d;
		end
	end

	always_ff @(posedge clk or posedge stage_clr)
	begin
		if (stage_clr)
		begin
			stage_q <= GSSR_STAGE_RST;
		end
		else
		begin
			stage_q <= stage_d;
		end
	end

	assign stage_out = stage_q;

	// A snapshot is offered after each shift; shifts never stall,
	// so a full FIFO drops the word and snap_ready shows it
	gssr_fifo #(
		.WIDTH (GSSR_STAGES),
		.DEPTH (GSSR_FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset     (reset),
		.clk_en    (clk_en),
		.in_valid  (shift_edge && async_clear_n),
		.in_ready  (snap_ready),
		.in_data   (stage_d),
		.out_valid (word_valid),
		.out_ready (word_ready),
		.out_data  (word_data)
	);

endmodule

/* verif/gssr_chk.sv */
/* Port checks. Assumes one clk domain, reset high. */
`timescale 1ns/100ps
module gssr_chk
	import gssr_pkg::*;
(
	input wire logic         clk,
	input wire logic         reset,
	input wire logic         clk_en,
	input wire gssr_serial_t serial_in,
	input wire logic         async_clear_n,
	input wire gssr_word_t   stage_out,
	input wire logic         word_valid,
	input wire logic         word_ready,
	input wire gssr_word_t   word_data,
	input wire logic         snap_ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic prev_q;
	wire  g = serial_in.gate_a & serial_in.gate_b;
	wire  sh = clk_en & serial_in.shift_clock & ~prev_q & async_clear_n;
	// Preset high, so a clock already high at release is no edge
	always_ff @(posedge clk or posedge reset)
		if (reset)
			prev_q <= 1'b1;
		else if (clk_en)
			prev_q <= serial_in.shift_clock;
	clr_zero_a: assert property (!async_clear_n |-> !stage_out)
		else $error("no clear");
	shift_up_a: assert property (sh |=> stage_out[7:1] == $past(stage_out[6:0]))
		else $error("bad shift");
	first_bit_a: assert property (sh |=> stage_out[0] == $past(g))
		else $error("bad bit");
	hold_a: assert property (!sh && async_clear_n |=> $stable(stage_out) || !async_clear_n)
		else $error("moved");
	push_a: assert property (sh && snap_ready |=> word_valid)
		else $error("no push");
	head_a: assert property (sh && !word_valid |=> word_data == stage_out)
		else $error("bad word");
	full_a: assert property (!snap_ready |-> word_valid)
		else $error("bad full");
	word_hold_a: assert property (word_valid && !word_ready |=> $stable(word_data))
		else $error("word moved");
endmodule
bind gssr_shift_register gssr_chk u_chk (.*);

/* verif/gssr_drv.sv */
/* Driving logic model. Assumes the bench clk. */
`timescale 1ns/100ps
module gssr_drv
	import gssr_pkg::*;
(
	input wire logic   clk,
	output gssr_serial_t serial_in,
	output logic         async_clear_n
);
	initial
	begin
		serial_in = '0;
		async_clear_n = 1'b1;
	end
	task automatic shift(input logic a, input logic b);
		@(negedge clk) serial_in <= {1'b0, a, b};
		@(negedge clk) serial_in.shift_clock <= 1'b1;
		// Gates move while high, must be ignored
		@(negedge clk) serial_in <= {1'b1, ~a, ~b};
	endtask
	task automatic clear();
		@(negedge clk) async_clear_n <= 1'b0;
		@(negedge clk) async_clear_n <= 1'b1;
	endtask
endmodule

/* verif/tb_gated_serial_shift_register.sv */
/* Bench with a queue model. Assumes the driver model. */
`timescale 1ns/100ps
module tb_gated_serial_shift_register;
	import gssr_pkg::*;
	logic         clk = 1'b0, reset = 1'b1, clk_en = 1'b1, word_ready = 1'b0;
	logic         async_clear_n, word_valid, snap_ready;
	gssr_serial_t serial_in;
	gssr_word_t   stage_out, word_data, m;
	gssr_word_t   q[$];
	integer       seed = 32'h0000_0641, err_total = 0, cmp_count = 0, i;
	always #5 clk = ~clk;
	gssr_drv u_drv (.clk(clk), .serial_in(serial_in), .async_clear_n(async_clear_n));
	gssr_shift_register u_dut (.*);
	task chk(input string n, input gssr_word_t e, input gssr_word_t s);
		cmp_count++;
		if (s !== e)
		begin
			err_total++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task wrap_up();
		$display("checks %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task sh(input logic a, input logic b);
		u_drv.shift(a, b);
		if (clk_en)
		begin
			m = {m[6:0], a & b};
			if (q.size() < GSSR_FIFO_DEPTH)
				q.push_back(m);
		end
		chk("stage", m, stage_out);
	endtask
	initial
	begin
		repeat (10) @(negedge clk);
		reset = 1'b0;
		u_drv.clear();
		m = 8'h00;
		for (i = 0; i < 10; i++)
			sh(i[0], i[1] | i[2]);
		chk("ready", 8'h00, {7'h00, snap_ready});
		clk_en = 1'b0;
		sh(1'b1, 1'b1);
		clk_en = 1'b1;
		for (i = 0; i < 60 && q.size() > 0; i++)
		begin
			@(negedge clk);
			if (word_valid === 1'b1)
				chk("word", q[0], word_data);
			word_ready = 1'($random(seed));
			if (word_valid === 1'b1 && word_ready)
				void'(q.pop_front());
		end
		@(negedge clk) word_ready = 1'b0;
		chk("left", 8'h00, 8'(q.size()));
		chk("valid", 8'h00, {7'h00, word_valid});
		u_drv.clear();
		chk("cleared", 8'h00, stage_out);
		m = 8'h00;
		sh(1'b1, 1'b1);
		// Reset mid-run while shift_clock stays high: no false edge
		@(negedge clk) reset = 1'b1;
		@(negedge clk) reset = 1'b0;
		m = 8'h00;
		q.delete();
		chk("rst stage", 8'h00, stage_out);
		chk("rst valid", 8'h00, {7'h00, word_valid});
		chk("rst ready", 8'h01, {7'h00, snap_ready});
		sh(1'b1, 1'b0);
		sh(1'b1, 1'b1);
		wrap_up();
	end
	initial
	begin
		#100000;
		err_total++;
		wrap_up();
	end
endmodule
